/* core/pfd_dt_if.sv */
// Purpose: Carrier between the top and the dead-time pair module
// Assumes: One clock domain
// Notes: Top drives counts and input; pair drives the two sides
`timescale 1ns/1ps
interface pfd_dt_if;
    logic en;
    logic wave_in;
    logic [7:0] low_count;
    logic [7:0] high_count;
    logic low_side;
    logic high_side;
    modport ctl (output en, wave_in, low_count, high_count,
                 input low_side, high_side);
    modport pair (input en, wave_in, low_count, high_count,
                  output low_side, high_side);
endinterface

/* core/pfd_dt_pair.sv */
// Purpose: Dead-time generator for one complementary output pair
// Assumes: Counts are in aclk cycles
// Notes: Rising edge of each side is delayed by that side's count
`timescale 1ns/1ps
module pfd_dt_pair (
    input wire logic aclk,
    input wire logic aresetn,
    pfd_dt_if.pair dt
);
    import pfd_pkg::*;

    logic [7:0] cnt_reg, cnt_next;
    logic prev_reg, prev_next;
    logic low_reg, low_next, high_reg, high_next;

    // -------------------------------------------------------------
    // Next state: restart count on each input change
    // -------------------------------------------------------------
    always_comb begin
        prev_next = dt.wave_in;
        cnt_next = cnt_reg;
        low_next = 1'b0;
        high_next = 1'b0;
        if (dt.en) begin
            if (dt.wave_in != prev_reg) begin
                cnt_next = 8'h00;
            end else if (cnt_reg != 8'hff) begin
                cnt_next = cnt_reg + 8'h01;
            end
            // Both sides off until the count runs out
            if (dt.wave_in == prev_reg) begin
                high_next = dt.wave_in && (cnt_reg >= dt.high_count);
                low_next = !dt.wave_in && (cnt_reg >= dt.low_count);
            end
        end
    end

    // Registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= 8'h00;
            prev_reg <= 1'b0;
            low_reg <= 1'b0;
            high_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            prev_reg <= prev_next;
            low_reg <= low_next;
            high_reg <= high_next;
        end
    end

    assign dt.low_side = low_reg;
    assign dt.high_side = high_reg;

    a_dt_no_overlap: assert property (@(posedge aclk) disable iff (!aresetn)
        !(low_reg && high_reg)) else $error("both sides active");
    a_dt_high_delay: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(high_reg) |-> cnt_reg > dt.high_count || dt.high_count == 8'hff
        || $past(cnt_reg) >= dt.high_count)
        else $error("high side rose early");
endmodule

/* core/pfd_pkg.sv */
// Purpose: Shared constants for the fault, dead-time and output driver block
// Assumes: 32-bit AXI4-Lite register bus, 200 MHz clock
// Notes: Field positions and codes are named here only
package pfd_pkg;
    // -------------------------------------------------------------
    // Register byte offsets
    // -------------------------------------------------------------
    localparam logic [7:0] PFD_FAULT_A_OFS = 8'h0c;
    localparam logic [7:0] PFD_FAULT_B_OFS = 8'h10;
    localparam logic [7:0] PFD_WEX_OFS = 8'h14;
    localparam logic [7:0] PFD_DRV_OFS = 8'h18;
    localparam logic [7:0] PFD_STAT_OFS = 8'h1c;
    localparam logic [31:0] PFD_RESET_VAL = 32'h0000_0000;
    // -------------------------------------------------------------
    // Fault control fields
    // -------------------------------------------------------------
    localparam int PFD_F_SRC_LO = 0;
    localparam int PFD_F_KEEP = 3;
    localparam int PFD_F_GATE = 4;
    localparam int PFD_F_BLANK_LO = 5;
    localparam int PFD_F_RESTART = 7;
    localparam int PFD_F_HALT_LO = 8;
    localparam int PFD_F_BLANKLEN_LO = 16;
    localparam int PFD_F_FILT_LO = 24;
    // Write mask of implemented fault control bits
    localparam logic [31:0] PFD_FAULT_MASK = 32'h0fff_7ffb;
    // -------------------------------------------------------------
    // Waveform extension and driver fields
    // -------------------------------------------------------------
    localparam int PFD_W_ROUTE_LO = 0;
    localparam int PFD_W_DTEN_LO = 8;
    localparam int PFD_W_DTLO_LO = 16;
    localparam int PFD_W_DTHI_LO = 24;
    localparam logic [31:0] PFD_WEX_MASK = 32'hffff_0f03;
    localparam int PFD_D_OVEN_LO = 0;
    localparam int PFD_D_OVLVL_LO = 8;
    localparam int PFD_D_INV_LO = 16;
    localparam int PFD_D_FILT0_LO = 24;
    localparam int PFD_D_FILT1_LO = 28;
    // -------------------------------------------------------------
    // Codes
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        PFD_HALT_NONE = 2'h0,
        PFD_HALT_HW = 2'h1,
        PFD_HALT_SW = 2'h2,
        PFD_HALT_ESC = 2'h3
    } pfd_halt_e;
    typedef enum logic [1:0] {
        PFD_BLK_START = 2'h0,
        PFD_BLK_RISE = 2'h1,
        PFD_BLK_FALL = 2'h2,
        PFD_BLK_BOTH = 2'h3
    } pfd_blank_e;
    typedef enum logic [1:0] {
        PFD_SRC_OFF = 2'h0,
        PFD_SRC_EVT = 2'h1,
        PFD_SRC_INV = 2'h2,
        PFD_SRC_ALT = 2'h3
    } pfd_src_e;
    localparam logic [1:0] PFD_RESP_OKAY = 2'h0;
    localparam logic [1:0] PFD_RESP_SLVERR = 2'h2;
endpackage

/* core/pfd_top.sv */
// Purpose: Fault handling, dead time and output driver of a PWM timer
// Assumes: Waveform, compare and cycle inputs come from the counter core
// Notes: Event and fault inputs are synchronised by two flip-flops
//
// Overview of operation
// - Halt field selects none, hardware, software, escalate.
// - Resume bit enables restart action per fault.
// - Blanking starts at period, rise, fall, toggle.
// - Qualification ignores fault while compare output inactive.
// - Hold keeps fault state until cycle end.
// - Source: off, event, inverted event, other fault.
// - High-side dead time from upper byte.
// - Low-side dead time from bits 23:16.
// - Enabled pair drives x low, x+half high.
// - Routing select chooses waveform-to-pin mapping.
// - Four-bit filters on both non-recoverable inputs.
// - Invert bit inverts its waveform output.
// - Overridden output forced to override level.
// - Override enable picks outputs replaced under fault.
// - Blanking masks fault for programmed count.
// - Option: tri-state or drive override level.
`timescale 1ns/1ps
module pfd_top #(
    parameter int NOUT = 8,
    parameter int NPAIR = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NOUT-1:0] wave_gen,
    input wire logic [1:0] compare_output_level,
    input wire logic cycle_start,
    input wire logic cycle_end,
    input wire logic [1:0] channel_event_input,
    input wire logic timer_event_input_0,
    input wire logic timer_event_input_1,
    input wire logic nonrecov_drive_mode,
    output logic [NOUT-1:0] waveform_output,
    output logic [NOUT-1:0] waveform_output_oe_n,
    output logic [1:0] fault_active,
    output logic [1:0] fault_restart,
    output logic [1:0] fault_hw_halt,
    output logic [1:0] fault_sw_halt,
    output logic nonrecov_fault
);
    import pfd_pkg::*;

    // -------------------------------------------------------------
    // Register file and AXI4-Lite slave
    // -------------------------------------------------------------
    logic [31:0] fctl_reg [2];
    logic [31:0] fctl_next [2];
    logic [31:0] wex_reg, wex_next, drv_reg, drv_next;
    logic aw_reg, aw_next, w_reg, w_next, bv_reg, bv_next;
    logic [7:0] awa_reg, awa_next;
    logic [31:0] wd_reg, wd_next;
    logic [3:0] ws_reg, ws_next;
    logic [1:0] br_reg, br_next, rr_reg, rr_next;
    logic rv_reg, rv_next;
    logic [31:0] rd_reg, rd_next;
    logic [31:0] wmask;
    logic [31:0] status;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] val,
                                          input logic [3:0] be,
                                          input logic [31:0] msk);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[i*8 +: 8] = val[i*8 +: 8];
        end
        return r & msk;
    endfunction

    // Capture address and data in either order, then answer
    always_comb begin
        aw_next = aw_reg;
        w_next = w_reg;
        awa_next = awa_reg;
        wd_next = wd_reg;
        ws_next = ws_reg;
        bv_next = bv_reg;
        br_next = br_reg;
        fctl_next = fctl_reg;
        wex_next = wex_reg;
        drv_next = drv_reg;
        wmask = 32'h0000_0000;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_next = 1'b1;
            awa_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_next = 1'b1;
            wd_next = s_axi_wdata;
            ws_next = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bv_next = 1'b0;
        end
        if (aw_reg && w_reg && !bv_reg) begin
            aw_next = 1'b0;
            w_next = 1'b0;
            bv_next = 1'b1;
            br_next = PFD_RESP_OKAY;
            if (awa_reg == PFD_FAULT_A_OFS) begin
                fctl_next[0] = merge(fctl_reg[0], wd_reg, ws_reg,
                                     PFD_FAULT_MASK);
            end else if (awa_reg == PFD_FAULT_B_OFS) begin
                fctl_next[1] = merge(fctl_reg[1], wd_reg, ws_reg,
                                     PFD_FAULT_MASK);
            end else if (awa_reg == PFD_WEX_OFS) begin
                wex_next = merge(wex_reg, wd_reg, ws_reg, PFD_WEX_MASK);
            end else if (awa_reg == PFD_DRV_OFS) begin
                wmask = ~32'h0000_0000;
                drv_next = merge(drv_reg, wd_reg, ws_reg, wmask);
            end else if (awa_reg == PFD_STAT_OFS) begin
                br_next = PFD_RESP_OKAY;
            end else begin
                br_next = PFD_RESP_SLVERR;
            end
        end
    end

    // Read channel: one cycle answer
    always_comb begin
        rv_next = rv_reg;
        rd_next = rd_reg;
        rr_next = rr_reg;
        if (s_axi_rvalid && s_axi_rready) begin
            rv_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rv_next = 1'b1;
            rr_next = PFD_RESP_OKAY;
            if (s_axi_araddr == PFD_FAULT_A_OFS) begin
                rd_next = fctl_reg[0];
            end else if (s_axi_araddr == PFD_FAULT_B_OFS) begin
                rd_next = fctl_reg[1];
            end else if (s_axi_araddr == PFD_WEX_OFS) begin
                rd_next = wex_reg;
            end else if (s_axi_araddr == PFD_DRV_OFS) begin
                rd_next = drv_reg;
            end else if (s_axi_araddr == PFD_STAT_OFS) begin
                rd_next = status;
            end else begin
                rd_next = 32'h0000_0000;
                rr_next = PFD_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_reg <= 1'b0;
            w_reg <= 1'b0;
            awa_reg <= 8'h00;
            wd_reg <= PFD_RESET_VAL;
            ws_reg <= 4'h0;
            bv_reg <= 1'b0;
            br_reg <= PFD_RESP_OKAY;
            fctl_reg[0] <= PFD_RESET_VAL;
            fctl_reg[1] <= PFD_RESET_VAL;
            wex_reg <= PFD_RESET_VAL;
            drv_reg <= PFD_RESET_VAL;
            rv_reg <= 1'b0;
            rd_reg <= PFD_RESET_VAL;
            rr_reg <= PFD_RESP_OKAY;
        end else begin
            aw_reg <= aw_next;
            w_reg <= w_next;
            awa_reg <= awa_next;
            wd_reg <= wd_next;
            ws_reg <= ws_next;
            bv_reg <= bv_next;
            br_reg <= br_next;
            fctl_reg <= fctl_next;
            wex_reg <= wex_next;
            drv_reg <= drv_next;
            rv_reg <= rv_next;
            rd_reg <= rd_next;
            rr_reg <= rr_next;
        end
    end

    assign s_axi_awready = !aw_reg && !bv_reg;
    assign s_axi_wready = !w_reg && !bv_reg;
    assign s_axi_bvalid = bv_reg;
    assign s_axi_bresp = br_reg;
    assign s_axi_arready = !rv_reg;
    assign s_axi_rvalid = rv_reg;
    assign s_axi_rdata = rd_reg;
    assign s_axi_rresp = rr_reg;

    // -------------------------------------------------------------
    // Input synchronisers and non-recoverable filters
    // -------------------------------------------------------------
    logic [3:0] s1_reg, s2_reg;
    logic [1:0] hard_in;
    logic [3:0] flt_reg [2];
    logic [3:0] flt_next [2];
    logic [1:0] hard_reg, hard_next;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_reg <= 4'h0;
            s2_reg <= 4'h0;
        end else begin
            s1_reg <= {timer_event_input_1, timer_event_input_0,
                       channel_event_input};
            s2_reg <= s1_reg;
        end
    end
    assign hard_in = s2_reg[3:2];

    // Input must stay stable for filter+1 cycles to change
    always_comb begin
        for (int n = 0; n < 2; n++) begin
            logic [3:0] lim;
            lim = (n == 0) ? drv_reg[PFD_D_FILT0_LO +: 4]
                           : drv_reg[PFD_D_FILT1_LO +: 4];
            flt_next[n] = 4'h0;
            hard_next[n] = hard_reg[n];
            if (hard_in[n] != hard_reg[n]) begin
                if (flt_reg[n] >= lim) begin
                    hard_next[n] = hard_in[n];
                end else begin
                    flt_next[n] = flt_reg[n] + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flt_reg[0] <= 4'h0;
            flt_reg[1] <= 4'h0;
            hard_reg <= 2'b00;
        end else begin
            flt_reg <= flt_next;
            hard_reg <= hard_next;
        end
    end

    // -------------------------------------------------------------
    // Recoverable faults A and B
    // -------------------------------------------------------------
    logic [1:0] fst_reg, fst_next, prevf_reg, prevf_next;
    logic [7:0] blk_reg [2];
    logic [7:0] blk_next [2];
    logic [1:0] cmp_prev_reg;
    logic [1:0] esc;

    always_comb begin
        prevf_next = prevf_reg;
        if (cycle_end) prevf_next = fst_reg;
        for (int n = 0; n < 2; n++) begin
            logic [31:0] c;
            logic raw, edge_hit, rise, fall;
            c = fctl_reg[n];
            rise = compare_output_level[n] && !cmp_prev_reg[n];
            fall = !compare_output_level[n] && cmp_prev_reg[n];
            // Source selection
            case (pfd_src_e'(c[PFD_F_SRC_LO +: 2]))
                PFD_SRC_EVT: raw = s2_reg[n];
                PFD_SRC_INV: raw = !s2_reg[n];
                PFD_SRC_ALT: raw = prevf_reg[1-n];
                default: raw = 1'b0;
            endcase
            // Qualification gate on inactive compare level
            if (c[PFD_F_GATE] && !compare_output_level[n]) raw = 1'b0;
            // Blanking start point
            case (pfd_blank_e'(c[PFD_F_BLANK_LO +: 2]))
                PFD_BLK_START: edge_hit = cycle_start;
                PFD_BLK_RISE: edge_hit = rise;
                PFD_BLK_FALL: edge_hit = fall;
                default: edge_hit = rise || fall;
            endcase
            // Blanking window counts down
            blk_next[n] = blk_reg[n];
            if (edge_hit) begin
                blk_next[n] = c[PFD_F_BLANKLEN_LO +: 8];
            end else if (blk_reg[n] != 8'h00) begin
                blk_next[n] = blk_reg[n] - 8'h01;
            end
            if (blk_reg[n] != 8'h00 || (edge_hit &&
                c[PFD_F_BLANKLEN_LO +: 8] != 8'h00)) raw = 1'b0;
            // Hold until cycle end or follow the input
            if (raw) begin
                fst_next[n] = 1'b1;
            end else if (!c[PFD_F_KEEP] || cycle_end) begin
                fst_next[n] = 1'b0;
            end else begin
                fst_next[n] = fst_reg[n];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fst_reg <= 2'b00;
            prevf_reg <= 2'b00;
            cmp_prev_reg <= 2'b00;
            blk_reg[0] <= 8'h00;
            blk_reg[1] <= 8'h00;
        end else begin
            fst_reg <= fst_next;
            prevf_reg <= prevf_next;
            cmp_prev_reg <= compare_output_level;
            blk_reg <= blk_next;
        end
    end

    // Halt and restart actions per fault
    generate
        for (genvar n = 0; n < 2; n++) begin : g_act
            pfd_halt_e h;
            assign h = pfd_halt_e'(fctl_reg[n][PFD_F_HALT_LO +: 2]);
            assign fault_hw_halt[n] = fst_reg[n] && h == PFD_HALT_HW;
            assign fault_sw_halt[n] = fst_reg[n] && h == PFD_HALT_SW;
            assign esc[n] = fst_reg[n] && h == PFD_HALT_ESC;
            assign fault_restart[n] = fctl_reg[n][PFD_F_RESTART] &&
                                      fst_reg[n] && !fst_next[n];
        end
    endgenerate
    assign fault_active = fst_reg;
    assign nonrecov_fault = |hard_reg || |esc;
    assign status = {29'h0, nonrecov_fault, fst_reg};

    a_keep_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        fst_reg[0] && fctl_reg[0][PFD_F_KEEP] && !cycle_end
        |=> fst_reg[0]) else $error("fault released before cycle end");
    a_src_off: assert property (@(posedge aclk) disable iff (!aresetn)
        fctl_reg[0][PFD_F_SRC_LO +: 2] == 2'h0 && !fctl_reg[0][PFD_F_KEEP]
        ##1 fctl_reg[0][PFD_F_SRC_LO +: 2] == 2'h0 |-> !fst_reg[0])
        else $error("disabled source set fault");

    // -------------------------------------------------------------
    // Routing, dead time, inversion and override
    // -------------------------------------------------------------
    logic [NOUT-1:0] routed, dt_out, drv_val;
    logic [NOUT-1:0] out_reg, out_next, oen_reg, oen_next;

    // Routing select; code 1 rotates, code 2 copies bit 0 to all, code 3 copies bit 1 into bit 0
    always_comb begin
        case (wex_reg[PFD_W_ROUTE_LO +: 2])
            2'h1: routed = {wave_gen[NOUT-2:0], wave_gen[NOUT-1]};
            2'h2: routed = {NOUT{wave_gen[0]}};
            2'h3: routed = {wave_gen[NOUT-1:1], wave_gen[1]};
            default: routed = wave_gen;
        endcase
    end

    generate
        for (genvar p = 0; p < NPAIR; p++) begin : g_dt
            pfd_dt_if dti ();
            assign dti.en = wex_reg[PFD_W_DTEN_LO + p];
            assign dti.wave_in = routed[p];
            assign dti.high_count = wex_reg[PFD_W_DTHI_LO +: 8];
            assign dti.low_count = wex_reg[PFD_W_DTLO_LO +: 8];
            pfd_dt_pair u_pair (
                .aclk(aclk),
                .aresetn(aresetn),
                .dt(dti.pair)
            );
            // Pair x drives low side at x, high at x+half
            assign dt_out[p] = dti.en ? dti.low_side : routed[p];
            assign dt_out[p+NPAIR] = dti.en ? dti.high_side
                                            : routed[p+NPAIR];
        end
    endgenerate

    // Inversion, then override under non-recoverable fault
    always_comb begin
        drv_val = dt_out ^ drv_reg[PFD_D_INV_LO +: NOUT];
        out_next = drv_val;
        oen_next = {NOUT{1'b0}};
        for (int i = 0; i < NOUT; i++) begin
            if (nonrecov_fault && drv_reg[PFD_D_OVEN_LO + i]) begin
                out_next[i] = drv_reg[PFD_D_OVLVL_LO + i];
                oen_next[i] = !nonrecov_drive_mode;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_reg <= {NOUT{1'b0}};
            oen_reg <= {NOUT{1'b0}};
        end else begin
            out_reg <= out_next;
            oen_reg <= oen_next;
        end
    end
    assign waveform_output = out_reg;
    assign waveform_output_oe_n = oen_reg;

    a_override_lvl: assert property (@(posedge aclk) disable iff (!aresetn)
        nonrecov_fault && drv_reg[PFD_D_OVEN_LO] |=>
        waveform_output[0] == $past(drv_reg[PFD_D_OVLVL_LO]))
        else $error("override level wrong");
    a_invert_out: assert property (@(posedge aclk) disable iff (!aresetn)
        !nonrecov_fault && !wex_reg[PFD_W_DTEN_LO] &&
        wex_reg[PFD_W_ROUTE_LO +: 2] == 2'h0 |=>
        waveform_output[0] == ($past(wave_gen[0]) ^
        $past(drv_reg[PFD_D_INV_LO]))) else $error("inversion wrong");
    a_tristate_opt: assert property (@(posedge aclk) disable iff (!aresetn)
        nonrecov_fault && drv_reg[PFD_D_OVEN_LO] && !nonrecov_drive_mode
        |=> waveform_output_oe_n[0]) else $error("no tri-state");
    a_no_override: assert property (@(posedge aclk) disable iff (!aresetn)
        !drv_reg[PFD_D_OVEN_LO] |=> !waveform_output_oe_n[0])
        else $error("disabled output overridden");
endmodule

/* verification/pfd_power_stage.sv */
// Purpose: Switch stages hanging on the output pins
// Assumes: A released pin is pulled low by the stage
// Notes: Overlap flags a leg with both switches on
`timescale 1ns/1ps
module pfd_power_stage (
    input wire logic [7:0] pin_val,
    input wire logic [7:0] pin_oe_n,
    output logic [7:0] pin_level,
    output logic overlap
);
    // Pin levels and shoot-through detect
    assign pin_level = pin_val & ~pin_oe_n;
    assign overlap = |(pin_level[3:0] & pin_level[7:4]);
endmodule

/* verification/tb_top.sv */
// Purpose: Bus-driven tests of fault, dead time and driver
// Assumes: Routing code 0 maps outputs straight through
// Notes: All tests end in results
`timescale 1ns/1ps
module tb_top;
    import pfd_pkg::*;
    logic aclk, aresetn, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
    logic cs, ce, t0, t1, md, nf, ov;
    logic [7:0] aw, ar, wg, pv, oe, lvl;
    logic [31:0] wd, rdat, q;
    logic [1:0] bresp, rresp, rsp, cmp, ev, fa, frs, fh, fs;
    int n_mismatch = 0, checks = 0, n_rs = 0, n_ov = 0;
    pfd_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .wave_gen(wg), .compare_output_level(cmp),
        .cycle_start(cs), .cycle_end(ce), .channel_event_input(ev),
        .timer_event_input_0(t0), .timer_event_input_1(t1),
        .nonrecov_drive_mode(md), .waveform_output(pv),
        .waveform_output_oe_n(oe), .fault_active(fa), .fault_restart(frs),
        .fault_hw_halt(fh), .fault_sw_halt(fs), .nonrecov_fault(nf));
    pfd_power_stage stage (.pin_val(pv), .pin_oe_n(oe), .pin_level(lvl),
        .overlap(ov));
    // Clock and pin monitors
    initial begin
        aclk = 0;
        forever #2.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        if (frs[0] === 1'b1) n_rs++;
        if (ov === 1'b1) n_ov++;
    end
    task chk(input logic [63:0] s, input logic [63:0] e);
        checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        aw <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        br <= 1;
        do begin
            @(posedge aclk);
            if (awr) awv <= 0;
            if (wrd) wv <= 0;
        end while (!((awr || !awv) && (wrd || !wv)));
        do @(posedge aclk); while (bv !== 1'b1);
        rsp = bresp;
        br <= 0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge aclk);
        ar <= a;
        arv <= 1;
        rr <= 1;
        do @(posedge aclk); while (arr !== 1'b1);
        arv <= 0;
        do @(posedge aclk); while (rv !== 1'b1);
        q = rdat;
        rsp = rresp;
        rr <= 0;
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #100000;
        n_mismatch++;
        results();
    end
    // Test sequence
    initial begin
        {awv, wv, br, arv, rr, cs, ce, t0, t1, md, aw, ar, wd, wg, ev} = '0;
        cmp = 2'h3;
        aresetn = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        for (int i = 0; i < 4; i++) begin
            rd(8'h0c + 8'(4 * i));
            chk(q, PFD_RESET_VAL);
        end
        wr(PFD_WEX_OFS, 32'hffff_ffff);
        rd(PFD_WEX_OFS);
        chk(q, PFD_WEX_MASK);
        rd(8'h04);
        chk({q, rsp}, {32'h0, PFD_RESP_SLVERR});
        wr(8'h00, 32'h1);
        chk(rsp, PFD_RESP_SLVERR);
        wr(PFD_WEX_OFS, 32'h0);
        wg <= 8'h3c;
        wr(PFD_DRV_OFS, 32'h00ff_0000);
        repeat (4) @(posedge aclk);
        chk({pv, oe}, {8'hc3, 8'h00});
        md <= 1;
        wr(PFD_DRV_OFS, 32'h0000_050f);
        t0 <= 1;
        repeat (8) @(posedge aclk);
        chk({pv, nf}, {8'h35, 1'b1});
        md <= 0;
        repeat (3) @(posedge aclk);
        chk(oe, 8'h0f);
        t0 <= 0;
        for (int h = 1; h < 4; h++) begin
            wr(PFD_FAULT_A_OFS, 32'h1 | (32'(h) << 8));
            ev <= 2'b01;
            repeat (6) @(posedge aclk);
            chk({fh, fs, nf}, {1'b0, h == 1, 1'b0, h == 2, h == 3});
            ev <= 2'b00;
            repeat (10) @(posedge aclk);
            chk({fa, nf}, 3'b000);
        end
        wr(PFD_FAULT_A_OFS, 32'h0000_0189);
        ev <= 2'b01;
        repeat (6) @(posedge aclk);
        ev <= 2'b00;
        repeat (6) @(posedge aclk);
        chk(fa, 2'b01);
        ce <= 1;
        @(posedge aclk);
        ce <= 0;
        repeat (3) @(posedge aclk);
        chk({fa, 32'(n_rs)}, {2'b00, 32'h1});
        wr(PFD_FAULT_B_OFS, 32'h0000_0102);
        repeat (6) @(posedge aclk);
        chk(fa, 2'b10);
        ce <= 1;
        @(posedge aclk);
        ce <= 0;
        wr(PFD_FAULT_A_OFS, 32'h3);
        repeat (3) @(posedge aclk);
        chk(fa, 2'b11);
        wr(PFD_FAULT_B_OFS, 32'h0);
        ce <= 1;
        @(posedge aclk);
        ce <= 0;
        repeat (3) @(posedge aclk);
        chk(fa, 2'b00);
        ev <= 2'b01;
        cmp <= 2'h2;
        wr(PFD_FAULT_A_OFS, 32'h11);
        repeat (3) @(posedge aclk);
        chk(fa, 2'b00);
        wr(PFD_FAULT_A_OFS, 32'h0004_0021);
        repeat (3) @(posedge aclk);
        chk(fa, 2'b01);
        cmp <= 2'h3;
        repeat (3) @(posedge aclk);
        chk(fa, 2'b00);
        repeat (6) @(posedge aclk);
        chk(fa, 2'b01);
        ev <= 2'b00;
        wg <= 8'h00;
        wr(PFD_WEX_OFS, 32'h0c08_0100);
        repeat (20) @(posedge aclk);
        n_ov = 0;
        for (int i = 0; i < 4; i++) begin
            wg[0] <= !wg[0];
            repeat (4) @(posedge aclk);
            chk({pv[4], pv[0]}, 2'b00);
            repeat (8) @(posedge aclk);
            chk({pv[4], pv[0]}, {1'b0, i[0]});
            repeat (6) @(posedge aclk);
            chk(pv[4] ^ pv[0], 1'b1);
        end
        chk(n_ov, 0);
        results();
    end
endmodule
